// file: core/qddr_host_end.sv
// flash controller end: apb registers drive one read frame per start
// assumes the device end runs on a clock of the same rate
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "qddr_cfg.svh"
module qddr_host_end (
  input  wire logic         CLK_SYS,
  input  wire logic         RESET_N,
  input  wire logic [7:0]   PADDR,
  input  wire logic         PSEL,
  input  wire logic         PENABLE,
  input  wire logic         PWRITE,
  input  wire logic [31:0]  PWDATA,
  output logic      [31:0]  PRDATA,
  output logic              PREADY,
  output logic              PSLVERR,
  qddr_link_if.host         LINK
);

  localparam logic [4:0] HALF  = 5'(`SCK_HALF_CYCLES);
  localparam logic [4:0] Q1    = 5'(`SCK_HALF_CYCLES / 2);
  localparam logic [4:0] Q3    = 5'(`SCK_HALF_CYCLES + `SCK_HALF_CYCLES / 2);
  localparam logic [4:0] LAST  = 5'(2 * `SCK_HALF_CYCLES - 1);
  localparam logic [5:0] GAP   = 6'(`CS_GAP_CYCLES);

  // ==========================================================
  // registers and apb slave
  logic [13:0]             ctrl;
  logic [31:0]             addr_reg;
  logic [23:0]             cfg;
  logic [7:0]              learned;
  logic [7:0]              rcount;
  logic [31:0]             rdata;
  qddr_pkg::host_state_e   state;
  logic                    setup;
  logic                    wr;
  logic                    mapped;
  logic                    start;

  assign setup  = PSEL & ~PENABLE;
  assign wr     = PSEL & PENABLE & PREADY & PWRITE;
  assign mapped = PADDR == `REG_CTRL || PADDR == `REG_ADDR || PADDR == `REG_CFG
                  || PADDR == `REG_STATUS || PADDR == `REG_RDATA;
  assign start  = wr & (PADDR == `REG_CTRL) & (state == qddr_pkg::H_IDLE);

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & ~mapped;
      PRDATA  <= 32'h0;
      if (setup & ~PWRITE) begin
        if (PADDR == `REG_CTRL) begin
          PRDATA <= {18'h0, ctrl};
        end else if (PADDR == `REG_ADDR) begin
          PRDATA <= addr_reg;
        end else if (PADDR == `REG_CFG) begin
          PRDATA <= {8'h0, cfg};
        end else if (PADDR == `REG_STATUS) begin
          PRDATA <= {8'h0, rcount, learned, 7'h0, state != qddr_pkg::H_IDLE};
        end else if (PADDR == `REG_RDATA) begin
          PRDATA <= rdata;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl     <= 14'h0;
      addr_reg <= 32'h0;
      cfg      <= 24'h0;
    end else if (wr) begin
      // a busy controller ignores a new start
      if (start) begin
        ctrl <= PWDATA[13:0];
      end else if (PADDR == `REG_ADDR) begin
        addr_reg <= PWDATA;
      end else if (PADDR == `REG_CFG) begin
        cfg <= PWDATA[23:0];
      end
    end
  end

  // ==========================================================
  // serial clock and frame sequencer
  logic [3:0]              meta;
  logic [3:0]              io_sync;
  logic [4:0]              ph;
  logic                    sck;
  logic                    cs_n;
  qddr_pkg::nibble_t       io_out;
  logic                    io_oe;
  logic [3:0]              u;
  logic [31:0]             ashift;
  logic [10:0]             pe;
  logic                    hi_seen;
  qddr_pkg::nibble_t       nib_hi;
  logic [5:0]              gap;
  logic                    run;
  logic                    edge_now;
  logic                    launch;
  logic                    ddr;
  logic [10:0]             two_l;
  logic [3:0]              instr_last;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      meta    <= 4'hf;
      io_sync <= 4'hf;
    end else begin
      meta    <= LINK.io;
      io_sync <= meta;
    end
  end

  assign ddr        = ctrl[`CTRL_DDR];
  assign two_l      = {6'h0, cfg[`CFG_LAT_LSB +: 4], 1'b0};
  assign run        = state != qddr_pkg::H_IDLE & ~(state == qddr_pkg::H_END & ~sck);
  assign edge_now   = run & (ph == LAST | ph == HALF - 5'd1);
  assign launch     = ph == Q3 | (ph == Q1 & ddr & (state == qddr_pkg::H_MODE
                      | (state == qddr_pkg::H_ADDR & u != 4'd0)));
  assign instr_last = (ctrl[`CTRL_QPI] & ~ctrl[`CTRL_MRST]) ? 4'd1 : 4'd7;

  // fixed 80 ns period keeps ddr reads well under the clock limit          // RULE_12
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ph  <= 5'h0;
      sck <= 1'b0;
    end else if (start) begin
      ph  <= HALF;
      sck <= 1'b0;
    end else if (run) begin
      ph  <= (ph == LAST) ? 5'h0 : ph + 5'd1;
      sck <= (ph == LAST) | (ph < HALF - 5'd1);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state   <= qddr_pkg::H_IDLE;
      cs_n    <= 1'b1;
      io_out  <= 4'hf;
      io_oe   <= 1'b0;
      u       <= 4'h0;
      ashift  <= 32'h0;
      pe      <= 11'h7ff;
      hi_seen <= 1'b0;
      nib_hi  <= 4'h0;
      learned <= 8'h0;
      rcount  <= 8'h0;
      rdata   <= 32'h0;
      gap     <= 6'h0;
    end else begin
      case (state)
        qddr_pkg::H_IDLE: begin
          if (start) begin
            cs_n    <= 1'b0;
            // mode reset ones come from the pull-up: a device still in ddr continuous may drive
            io_oe   <= ~PWDATA[`CTRL_MRST];
            u       <= 4'h0;
            rcount  <= 8'h0;
            learned <= 8'h0;
            hi_seen <= 1'b0;
            ashift  <= PWDATA[`CTRL_ADDR4] ? addr_reg : {addr_reg[23:0], 8'h0};
            // a continuous frame begins straight at the address
            state   <= (PWDATA[`CTRL_SKIP] & ~PWDATA[`CTRL_MRST]) ? qddr_pkg::H_ADDR
                                                                 : qddr_pkg::H_INSTR;
          end
        end
        qddr_pkg::H_INSTR: begin
          if (launch) begin
            u <= u + 4'd1;
            if (ctrl[`CTRL_MRST]) begin
              io_out <= 4'hf;                                                  // RULE_04
            end else if (ctrl[`CTRL_QPI]) begin
              io_out <= (u == 4'd0) ? ctrl[7:4] : ctrl[3:0];                   // RULE_08 RULE_20
            end else begin
              io_out <= {3'b111, ctrl[3'd7 - u[2:0]]};
            end
            if (u == instr_last) begin
              u     <= 4'h0;
              state <= ctrl[`CTRL_MRST] ? qddr_pkg::H_END : qddr_pkg::H_ADDR;
            end
          end
        end
        qddr_pkg::H_ADDR: begin
          if (launch) begin
            io_out <= ashift[31:28];
            ashift <= {ashift[27:0], 4'h0};
            u      <= u + 4'd1;
            if (u == (ctrl[`CTRL_ADDR4] ? `ADDR_UNITS_4B : `ADDR_UNITS_3B) - 4'd1) begin
              u     <= 4'h0;
              state <= qddr_pkg::H_MODE;
            end
          end
        end
        qddr_pkg::H_MODE: begin
          if (launch) begin
            io_out <= (u == 4'd0) ? cfg[7:4] : cfg[3:0];
            u      <= u + 4'd1;
            if (u == `MODE_UNITS - 4'd1) begin
              pe    <= 11'h7ff;
              state <= qddr_pkg::H_POST;
            end
          end
        end
        qddr_pkg::H_POST: begin
          // released before any device launch can follow the mode sample
          if (ph == Q1 | ph == Q3) begin
            io_oe <= 1'b0;                                                     // RULE_06 RULE_14
          end
          if (edge_now) begin
            pe <= pe + 11'd1;
            // a nibble launched on one edge is taken on the next edge
            if (pe != 11'h7ff & pe > two_l & (ddr | pe[0])) begin
              hi_seen <= ~hi_seen;
              nib_hi  <= io_sync;
              if (hi_seen) begin
                rdata  <= {rdata[23:0], nib_hi, io_sync};
                rcount <= rcount + 8'd1;
                if (rcount + 8'd1 == cfg[`CFG_CNT_LSB +: 8]) begin
                  state <= qddr_pkg::H_END;
                end
              end
            end else if (pe != 11'h7ff & ddr & ctrl[`CTRL_PRE] & pe <= two_l
                         & pe != 11'h0 & pe + 11'd7 >= two_l) begin
              learned <= {learned[6:0], io_sync[0]};
            end
          end
        end
        qddr_pkg::H_END: begin
          // cs stays low through mode and dummies; it rises only here      // RULE_07
          io_oe <= 1'b0;
          if (!sck) begin
            cs_n <= 1'b1;
            gap  <= gap + 6'd1;
            if (gap == GAP) begin
              gap   <= 6'h0;
              state <= qddr_pkg::H_IDLE;
            end
          end
        end
        default: begin
          state <= qddr_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign LINK.sck     = sck;
  assign LINK.cs_n    = cs_n;
  assign LINK.host_io = io_out;
  assign LINK.host_oe = io_oe;

endmodule : qddr_host_end

// file: core/qddr_cfg.svh
// constants shared by both ends of the four-line read link
// assumes a 250 MHz system clock on both ends
`ifndef QDDR_CFG_SVH
`define QDDR_CFG_SVH

// instruction codes
`define OP_QUAD_READ      8'heb
`define OP_QUAD_READ_4B   8'hec
`define OP_DDR_READ       8'hed
`define OP_DDR_READ_4B    8'hee
`define OP_MODE_RESET     8'hff

// mode byte and phase lengths, in units of one bit or nibble
`define MODE_CONTINUE     4'ha
`define INSTR_UNITS       4'd8
`define INSTR_UNITS_QPI   4'd2
`define ADDR_UNITS_3B     4'd6
`define ADDR_UNITS_4B     4'd8
`define MODE_UNITS        4'd2
`define PREAMBLE_EDGES    7'd8

// serial clock timing
`define SYS_PERIOD_NS     4
`define SCK_HALF_NS       40
`define SCK_MAX_DDR_MHZ   80
`define SCK_HALF_CYCLES   (`SCK_HALF_NS / `SYS_PERIOD_NS)
`define CS_GAP_CYCLES     (2 * `SCK_HALF_CYCLES)

// host register offsets
`define REG_CTRL          8'h00
`define REG_ADDR          8'h04
`define REG_CFG           8'h08
`define REG_STATUS        8'h0c
`define REG_RDATA         8'h10

// host register fields
`define CTRL_SKIP         8
`define CTRL_DDR          9
`define CTRL_QPI          10
`define CTRL_ADDR4        11
`define CTRL_MRST         12
`define CTRL_PRE          13
`define CFG_LAT_LSB       8
`define CFG_CNT_LSB       16

`endif

// file: core/qddr_pkg.sv
// state types of both ends of the four-line read link
// assumes qddr_cfg.svh for all numeric constants
package qddr_pkg;

  typedef enum logic [5:0] {
    DEV_IDLE   = 6'b000001,
    DEV_INSTR  = 6'b000010,
    DEV_ADDR   = 6'b000100,
    DEV_MODE   = 6'b001000,
    DEV_POST   = 6'b010000,
    DEV_IGNORE = 6'b100000
  } dev_state_e;

  typedef enum logic [5:0] {
    H_IDLE  = 6'b000001,
    H_INSTR = 6'b000010,
    H_ADDR  = 6'b000100,
    H_MODE  = 6'b001000,
    H_POST  = 6'b010000,
    H_END   = 6'b100000
  } host_state_e;

  typedef logic [3:0] nibble_t;

endpackage : qddr_pkg

// file: core/qddr_link_if.sv
// serial link between flash controller and flash device
// assumes both ends drive only their own signals; io pulls high when undriven
`timescale 1ns/1ps
interface qddr_link_if;
  logic                 sck;
  logic                 cs_n;
  qddr_pkg::nibble_t    host_io;
  logic                 host_oe;
  qddr_pkg::nibble_t    dev_io;
  logic                 dev_oe;
  qddr_pkg::nibble_t    io;

  // device drive wins so that contention is visible as host data loss
  assign io = dev_oe ? dev_io : (host_oe ? host_io : 4'hf);

  modport host (output sck, output cs_n, output host_io, output host_oe, input io);
  modport device (input sck, input cs_n, input io, output dev_io, output dev_oe);
endinterface : qddr_link_if

// file: core/qddr_flash_end.sv
// flash device end: four-line sdr/ddr read path with continuous read
// assumes sck half period of at least 6 system clocks; MEM_DATA combinational
// Function
// (RULE_01) sdr mode nibble A keeps continuous read
// (RULE_02) sdr low mode nibble is ignored
// (RULE_03) other sdr nibble exits at cs rise
// (RULE_04) mode reset returns to instruction commands
// (RULE_05) sdr: two mode cycles, then dummies
// (RULE_06) host releases io by first data fall
// (RULE_07) host holds cs low over mode/dummy
// (RULE_08) four-bit instruction mode: nibble per rise
// (RULE_09) quad reads need quad enable
// (RULE_10) ed three/four byte, ee four byte
// (RULE_11) ddr samples and drives both edges
// (RULE_12) host keeps ddr clock within limit
// (RULE_13) dummy count from latency code
// (RULE_14) host floats io during ddr dummies
// (RULE_15) complementary ddr mode enters continuous
// (RULE_16) non-complementary ddr mode exits continuous
// (RULE_17) address increments per byte, wraps
// (RULE_18) preamble in last four dummy cycles
// (RULE_19) same pattern on all four lines
// (RULE_20) four-bit instruction mode for ddr too
// (RULE_21) eb three/four byte, ec four byte
// (RULE_22) sdr data nibble on falling edge
// (RULE_23) continuous frame starts with address
`timescale 1ns/1ps
`include "qddr_cfg.svh"
module qddr_flash_end (
  input  wire logic         CLK_SYS,
  input  wire logic         RESET_N,
  qddr_link_if.device       LINK,
  input  wire logic         QUAD_ENABLE,
  input  wire logic         FOUR_BIT_INSTR,
  input  wire logic         ADDR_FOUR_BYTE,
  input  wire logic [3:0]   LATENCY,
  input  wire logic         PREAMBLE_EN,
  input  wire logic [7:0]   PREAMBLE_PATTERN,
  input  wire logic [7:0]   MEM_DATA,
  output logic      [31:0]  MEM_ADDR,
  output logic              CONT_SDR,
  output logic              CONT_DDR
);

  // ==========================================================
  // pin synchronisers
  logic [5:0]              meta;
  logic [5:0]              sync;
  logic [5:0]              prev;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      meta <= 6'h2f;
      sync <= 6'h2f;
      prev <= 6'h2f;
    end else begin
      meta <= {LINK.cs_n, LINK.sck, LINK.io};
      sync <= meta;
      prev <= sync;
    end
  end

  logic                    cs_rise;
  logic                    cs_fall;
  logic                    sck_rise;
  logic                    sck_fall;
  qddr_pkg::nibble_t       io_in;

  assign cs_rise  = sync[5] & ~prev[5];
  assign cs_fall  = ~sync[5] & prev[5];
  assign sck_rise = ~sync[5] & sync[4] & ~prev[4];
  assign sck_fall = ~sync[5] & ~sync[4] & prev[4];
  assign io_in    = sync[3:0];

  // ==========================================================
  // frame state
  qddr_pkg::dev_state_e    state;
  logic [3:0]              cnt;
  logic [31:0]             shift;
  logic [7:0]              mode;
  logic                    ddr;
  logic                    four;
  logic                    read_frame;
  logic [5:0]              pe;
  logic                    in_data;
  logic                    nib_lo;
  logic [7:0]              byte_buf;
  qddr_pkg::nibble_t       io_out;
  logic                    io_oe;

  logic                    any_edge;
  logic                    sample;
  logic [7:0]              next_instr;
  logic [3:0]              instr_last;
  logic [3:0]              addr_last;
  logic [5:0]              two_l;
  logic                    data_edge;
  logic                    pre_edge;
  logic [2:0]              pre_idx;

  assign any_edge   = sck_rise | sck_fall;
  // ddr address waits for its first rising edge, then takes both edges
  assign sample     = sck_rise | (sck_fall & ddr & (state == qddr_pkg::DEV_MODE
                      | cnt != 4'd0));                                          // RULE_11
  assign next_instr = FOUR_BIT_INSTR ? {shift[3:0], io_in}
                                     : {shift[6:0], io_in[0]};                  // RULE_08 RULE_20
  assign instr_last = (FOUR_BIT_INSTR ? `INSTR_UNITS_QPI : `INSTR_UNITS) - 4'd1;
  assign addr_last  = (four ? `ADDR_UNITS_4B : `ADDR_UNITS_3B) - 4'd1;
  assign two_l      = {1'b0, LATENCY, 1'b0};                                    // RULE_13
  // sdr launches only on falls, which are the even post-mode edges
  assign data_edge  = (state == qddr_pkg::DEV_POST) & any_edge
                      & (in_data | pe >= two_l) & (ddr | ~pe[0]);               // RULE_22 RULE_11
  assign pre_edge   = (state == qddr_pkg::DEV_POST) & any_edge & ~in_data
                      & (pe < two_l) & ddr & PREAMBLE_EN
                      & ({1'b0, pe} + `PREAMBLE_EDGES >= {1'b0, two_l});        // RULE_18
  assign pre_idx    = ~(pe[2:0] - two_l[2:0]);

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state      <= qddr_pkg::DEV_IDLE;
      cnt        <= 4'h0;
      shift      <= 32'h0;
      mode       <= 8'hff;
      ddr        <= 1'b0;
      four       <= 1'b0;
      read_frame <= 1'b0;
      pe         <= 6'h0;
      in_data    <= 1'b0;
      MEM_ADDR   <= 32'h0;
    end else if (cs_rise) begin
      state <= qddr_pkg::DEV_IDLE;
    end else if (cs_fall) begin
      cnt        <= 4'h0;
      shift      <= 32'h0;
      mode       <= 8'hff;
      read_frame <= CONT_SDR | CONT_DDR;
      // a continuous frame carries no instruction byte
      state      <= (CONT_SDR | CONT_DDR) ? qddr_pkg::DEV_ADDR
                                          : qddr_pkg::DEV_INSTR;               // RULE_23 RULE_01 RULE_15
    end else begin
      case (state)
        qddr_pkg::DEV_INSTR: begin
          if (sck_rise) begin
            shift <= {24'h0, next_instr};
            cnt   <= cnt + 4'd1;
            if (cnt == instr_last) begin
              cnt   <= 4'h0;
              shift <= 32'h0;
              state <= qddr_pkg::DEV_IGNORE;
              if (QUAD_ENABLE) begin                                           // RULE_09
                if (next_instr == `OP_QUAD_READ || next_instr == `OP_QUAD_READ_4B) begin
                  ddr        <= 1'b0;
                  four       <= (next_instr == `OP_QUAD_READ_4B) | ADDR_FOUR_BYTE; // RULE_21
                  read_frame <= 1'b1;
                  state      <= qddr_pkg::DEV_ADDR;
                end else if (next_instr == `OP_DDR_READ
                             || next_instr == `OP_DDR_READ_4B) begin
                  ddr        <= 1'b1;
                  four       <= (next_instr == `OP_DDR_READ_4B) | ADDR_FOUR_BYTE; // RULE_10
                  read_frame <= 1'b1;
                  state      <= qddr_pkg::DEV_ADDR;
                end
              end
              // mode reset and foreign codes simply idle out the frame      // RULE_04
            end
          end
        end
        qddr_pkg::DEV_ADDR: begin
          if (sample) begin
            shift <= {shift[27:0], io_in};
            cnt   <= cnt + 4'd1;
            if (cnt == addr_last) begin
              cnt      <= 4'h0;
              MEM_ADDR <= four ? {shift[27:0], io_in} : {8'h0, shift[19:0], io_in};
              state    <= qddr_pkg::DEV_MODE;
            end
          end
        end
        qddr_pkg::DEV_MODE: begin
          if (sample) begin
            mode <= {mode[3:0], io_in};
            cnt  <= cnt + 4'd1;
            if (cnt == `MODE_UNITS - 4'd1) begin                               // RULE_05
              pe      <= 6'h0;
              in_data <= 1'b0;
              state   <= qddr_pkg::DEV_POST;
            end
          end
        end
        qddr_pkg::DEV_POST: begin
          if (any_edge) begin
            pe <= pe + 6'd1;
          end
          if (data_edge) begin
            in_data <= 1'b1;
          end
          // wrap is the natural 32-bit roll-over
          if (data_edge & nib_lo) begin
            MEM_ADDR <= MEM_ADDR + 32'd1;                                      // RULE_17
          end
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end

  // ==========================================================
  // continuous read decision, taken when the frame closes
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      CONT_SDR <= 1'b0;
      CONT_DDR <= 1'b0;
    end else if (cs_rise) begin
      // a mode byte cut off before its first nibble stays at ff, which exits either mode
      CONT_SDR <= read_frame & ~ddr & (mode[7:4] == `MODE_CONTINUE);           // RULE_01 RULE_02 RULE_03 RULE_04
      CONT_DDR <= read_frame & ddr & (mode[7:4] == ~mode[3:0]);                // RULE_15 RULE_16 RULE_04
    end
  end

  // ==========================================================
  // output launch
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      io_out   <= 4'hf;
      io_oe    <= 1'b0;
      nib_lo   <= 1'b0;
      byte_buf <= 8'h0;
    end else if (cs_rise | cs_fall) begin
      io_oe  <= 1'b0;
      nib_lo <= 1'b0;
    end else if (data_edge) begin
      io_oe <= 1'b1;
      if (!nib_lo) begin
        io_out   <= MEM_DATA[7:4];
        byte_buf <= MEM_DATA;
        nib_lo   <= 1'b1;
      end else begin
        io_out <= byte_buf[3:0];
        nib_lo <= 1'b0;
      end
    end else if (pre_edge) begin
      io_oe  <= 1'b1;
      io_out <= {4{PREAMBLE_PATTERN[pre_idx]}};                                // RULE_19
    end
  end

  assign LINK.dev_io = io_out;
  assign LINK.dev_oe = io_oe;

endmodule : qddr_flash_end

// file: verif/qddr_link_chk.sv
// assertions on the wires between the two link ends
// assumes the host makes sck and cs_n, both ends run on CLK_SYS
`timescale 1ns/1ps
module qddr_link_chk (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic host_oe,
  input wire logic dev_oe
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // ==========
  // turnaround
  a_no_contention: assert property (!(host_oe && dev_oe))
    else $error("both ends drive io");
  a_host_released: assert property ($rose(dev_oe) |-> !$past(host_oe))
    else $error("host still drove io at device turn-on");
  a_dev_in_frame: assert property ($rose(dev_oe) |-> !cs_n)
    else $error("device drove io outside a frame");
  // quiet within synchroniser delay of cs rise
  a_dev_quiet_end: assert property ($rose(cs_n) |-> ##[0:8] !dev_oe)
    else $error("device kept io after frame end");
  // ==========
  // framing and clock
  a_cs_rise_idle: assert property ($rose(cs_n) |-> !sck)
    else $error("cs rose while sck high");
  a_cs_gap: assert property ($rose(cs_n) |-> cs_n[*8])
    else $error("cs high gap too short");
  a_sck_in_frame: assert property (sck |-> !cs_n)
    else $error("sck high outside frame");
  a_sck_high_len: assert property ($rose(sck) |-> sck[*8])
    else $error("sck high phase too short");
  a_sck_low_len: assert property ($fell(sck) |-> !sck[*8])
    else $error("sck low phase too short");
  c_dev_drive: cover property ($rose(dev_oe));
  c_frame: cover property ($fell(cs_n) ##[1:1000] $rose(cs_n));
  c_sck: cover property ($rose(sck) ##[1:30] $fell(sck));
endmodule : qddr_link_chk

// file: verif/tb.sv
// bench joining host end and flash end, reference model of read data
// assumes apb answer one cycle after setup and mem data combinational
`timescale 1ns/1ps
`include "qddr_cfg.svh"
module tb;
  logic        clk_sys, pready, pslverr, cont_sdr, cont_ddr, er;
  logic        reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        qe = 1'b1, fb = 1'b0, dl = 1'b0, pe = 1'b0;
  logic [3:0]  lat = 4'h0;
  logic [7:0]  paddr = 8'h0, pat = 8'h0, mem_data;
  logic [31:0] pwdata = 32'h0, prdata, mem_addr, rd;
  int          errors = 0, compares = 0, seed = 32'hca0b9abc;
  qddr_link_if link ();
  qddr_host_end u_qddr_host_end (.CLK_SYS(clk_sys), .RESET_N(reset_n), .PADDR(paddr),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  qddr_flash_end u_qddr_flash_end (.CLK_SYS(clk_sys), .RESET_N(reset_n), .LINK(link),
    .QUAD_ENABLE(qe), .FOUR_BIT_INSTR(fb), .ADDR_FOUR_BYTE(dl), .LATENCY(lat),
    .PREAMBLE_EN(pe), .PREAMBLE_PATTERN(pat), .MEM_DATA(mem_data), .MEM_ADDR(mem_addr),
    .CONT_SDR(cont_sdr), .CONT_DDR(cont_ddr));
  qddr_link_chk u_qddr_link_chk (.CLK_SYS(clk_sys), .RESET_N(reset_n), .sck(link.sck),
    .cs_n(link.cs_n), .host_oe(link.host_oe), .dev_oe(link.dev_oe));
  // ==========
  // memory model: address-dependent so a wrong increment shows
  function automatic logic [7:0] mb(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h96;
  endfunction : mb
  assign mem_data = mb(mem_addr);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic give_verdict();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // ==========
  // apb master: holds request until pready sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // f: pre, mrst, 4-byte, qpi, ddr, skip; ec: expected {sdr, ddr} continuous flags
  task automatic frame(input logic [7:0] op, input logic [5:0] f, input logic [31:0] ad,
                       input logic [7:0] md, input logic [3:0] lt, input logic [7:0] cn,
                       input logic [1:0] ec);
    logic [31:0] r, a, ex;
    logic        e;
    lat <= lt;
    pe <= f[5];
    fb <= f[2];
    dl <= f[3] & op[0];
    apb(1'b1, `REG_CFG, {8'h0, cn, 4'h0, lt, md}, r, e);
    apb(1'b1, `REG_ADDR, ad, r, e);
    apb(1'b1, `REG_CTRL, {18'h0, f, op}, r, e);
    do begin
      apb(1'b0, `REG_STATUS, 32'h0, r, e);
    end while (r[0] !== 1'b0);
    if (!f[4]) begin
      a = f[3] ? ad : {8'h0, ad[23:0]};
      ex = 32'h0;
      for (int i = 0; i < cn; i++) ex = {ex[23:0], (qe ? mb(a + i) : 8'hff)};
      chk({24'h0, r[23:16]}, {24'h0, cn});
      if (f[5]) chk({24'h0, r[15:8]}, {24'h0, pat});
      apb(1'b0, `REG_RDATA, 32'h0, r, e);
      chk(r, ex);
    end
    chk({30'h0, cont_sdr, cont_ddr}, {30'h0, ec});
  endtask : frame
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    pat <= 8'($random(seed));
    apb(1'b0, 8'h20, 32'h0, rd, er);
    chk({er, rd[30:0]}, {1'b1, 31'h0});
    frame(`OP_QUAD_READ, 6'h00, $random(seed), {4'ha, 4'($random(seed))}, 4'h2, 8'h4, 2'b10);
    frame(`OP_QUAD_READ, 6'h01, $random(seed), 8'h3c, 4'h0, 8'h5, 2'b00);
    frame(`OP_QUAD_READ_4B, 6'h08, 32'hfffffffe, 8'hff, 4'h3, 8'h4, 2'b00);
    frame(`OP_QUAD_READ, 6'h0c, $random(seed), 8'ha0, 4'h1, 8'h6, 2'b10);
    frame(`OP_MODE_RESET, 6'h10, 32'h0, 8'hff, 4'h1, 8'h4, 2'b00);
    frame(`OP_DDR_READ, 6'h2e, $random(seed), 8'h5a, 4'h4, 8'h4, 2'b01);
    frame(`OP_DDR_READ, 6'h2b, $random(seed), 8'h77, 4'h5, 8'h5, 2'b00);
    frame(`OP_DDR_READ_4B, 6'h0a, 32'hffffffff, 8'ha5, 4'h6, 8'h7, 2'b01);
    frame(`OP_MODE_RESET, 6'h10, 32'h0, 8'hff, 4'h1, 8'h4, 2'b00);
    qe <= 1'b0;
    frame(`OP_QUAD_READ, 6'h00, $random(seed), 8'ha0, 4'h2, 8'h4, 2'b00);
    give_verdict();
  end
endmodule : tb
